// *** rtl/spi_front_pkg.sv ***
// Constants and types shared by the serial flash front end.
`default_nettype none

package spi_front_pkg;

  // ****************************************
  // Serial framing.
  // ****************************************
  localparam int          BYTE_BITS    = 8;
  localparam logic [3:0]  SINGLE_STEP  = 4'h1;
  localparam logic [3:0]  DUAL_STEP    = 4'h2;
  localparam logic [3:0]  TX_CNT_EMPTY = 4'h0;
  localparam logic [2:0]  RX_CNT_LAST  = 3'h7;
  localparam logic [2:0]  RX_CNT_RST   = 3'h0;
  localparam logic [7:0]  IDLE_FILL    = 8'hFF;
  localparam logic [7:0]  BYTE_RST     = 8'h00;
  localparam int          FIFO_DEPTH   = 8;

  // ****************************************
  // Link timing.
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int SCK_PERIOD_NS  = 800;
  localparam int SCK_HALF_CYCLES = (SCK_PERIOD_NS / 2) / CLK_PERIOD_NS;

  // ****************************************
  // Frame states.
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_PAUSED = 3'b100
  } frame_state_t;

endpackage : spi_front_pkg

`default_nettype wire

// *** rtl/byte_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             in_ready_reg;
  logic             push;
  logic             pop;

  assign in_ready  = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign count_next = (push && !pop) ? count_reg + 1'b1
                    : (pop && !push) ? count_reg - 1'b1 : count_reg;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
      in_ready_reg <= 1'b1;
    end else begin
      count_reg    <= count_next;
      in_ready_reg <= (count_next != CNT_FULL);
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      end
    end
  end

endmodule : byte_fifo

`default_nettype wire

// *** rtl/serial_flash_spi_front_end.sv ***
// Serial interface front end of a small serial flash, oversampled on the system clock.
//
// Notes on behaviour
// RULE1: A low chip select selects the device; only then is serial traffic used.
// RULE2: Chip select high deselects, enters standby, and floats the serial output.
// RULE3: While deselected, serial input values are ignored entirely.
// RULE4: The host opens each operation with select falling and closes with it rising.
// RULE5: Deselect during a timed program or erase delays standby until it finishes.
// RULE6: Input bits are sampled at each rising serial clock edge.
// RULE7: Output changes only on falling serial clock edges.
// RULE8: Dual read turns the input pin into output lane zero, two bits per edge.
// RULE9: Dual read keeps the serial output driving as lane one.
// RULE10: Clock modes 0 and 3 only; either idle clock level works.
// RULE11: Pause low ignores clock and input and floats output; timed work continues.
// RULE12: The host starts a pause only while selected with the clock low.
// RULE13: Bytes move most significant bit first on each lane.
`default_nettype none

module serial_flash_spi_front_end
  import spi_front_pkg::*;
#(
  parameter int TX_DEPTH = FIFO_DEPTH
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  // Link pins.
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       hold_n,
  input  wire logic       dual_lane_zero_in,
  output logic            dual_lane_zero_out,
  output logic            dual_lane_zero_oe,
  output logic            dual_lane_one_out,
  output logic            dual_lane_one_oe,
  // Core side.
  input  wire logic       op_busy,
  input  wire logic       drive_en,
  input  wire logic       dual_mode,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            selected,
  output logic            standby,
  output logic            paused,
  output logic            frame_start,
  output logic            frame_end
);

  // ****************************************
  // Pin synchronisers.
  // ****************************************
  logic cs_n_meta_reg;
  logic cs_n_sync_reg;
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_prev_reg;
  logic hold_n_meta_reg;
  logic hold_n_sync_reg;
  logic si_meta_reg;
  logic si_sync_reg;

  // Every pin passes two flip-flops, and no logic reads the first stage.
  // The clock keeps a third stage so that its edges can be found by comparison.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cs_n_meta_reg   <= 1'b1;
      cs_n_sync_reg   <= 1'b1;
      sck_meta_reg    <= 1'b0;
      sck_sync_reg    <= 1'b0;
      sck_prev_reg    <= 1'b0;
      hold_n_meta_reg <= 1'b1;
      hold_n_sync_reg <= 1'b1;
      si_meta_reg     <= 1'b0;
      si_sync_reg     <= 1'b0;
    end else begin
      cs_n_meta_reg   <= cs_n;
      cs_n_sync_reg   <= cs_n_meta_reg;
      sck_meta_reg    <= sck;
      sck_sync_reg    <= sck_meta_reg;
      sck_prev_reg    <= sck_sync_reg;
      hold_n_meta_reg <= hold_n;
      hold_n_sync_reg <= hold_n_meta_reg;
      si_meta_reg     <= dual_lane_zero_in;
      si_sync_reg     <= si_meta_reg;
    end
  end

  wire sck_rise = sck_sync_reg && !sck_prev_reg;
  wire sck_fall = !sck_sync_reg && sck_prev_reg;

  // ****************************************
  // Frame state.
  // ****************************************
  frame_state_t state_reg;
  frame_state_t state_next;

  // A frame that opens while the pause pin is low goes straight to the paused state.
  // Deselect wins over pause, so a frame always closes when select rises.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!cs_n_sync_reg) begin
          state_next = hold_n_sync_reg ? ST_ACTIVE : ST_PAUSED; // RULE1 RULE4
        end
      end
      ST_ACTIVE: begin
        if (cs_n_sync_reg) begin
          state_next = ST_IDLE; // RULE2 RULE4
        end else if (!hold_n_sync_reg) begin
          state_next = ST_PAUSED; // RULE11 RULE12
        end
      end
      ST_PAUSED: begin
        if (cs_n_sync_reg) begin
          state_next = ST_IDLE;
        end else if (hold_n_sync_reg) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Edges count only while the frame is running and stays running this cycle.
  wire link_live  = (state_reg == ST_ACTIVE) && (state_next == ST_ACTIVE); // RULE1 RULE3 RULE11
  wire rise_act   = link_live && sck_rise; // RULE6
  wire fall_raw   = link_live && sck_fall;
  wire open_frame = (state_reg == ST_IDLE) && (state_next != ST_IDLE);
  wire close_frame = (state_reg != ST_IDLE) && (state_next == ST_IDLE);
  wire drive_now  = (state_next == ST_ACTIVE) && drive_en;

  // ****************************************
  // Clock mode handling.
  // ****************************************
  // In mode 3 the clock idles high, so the first edge after select is a falling
  // one that carries no data; it is skipped until a rising edge has been seen.
  logic seen_rise_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || open_frame) begin
      seen_rise_reg <= 1'b0; // RULE10
    end else if (rise_act) begin
      seen_rise_reg <= 1'b1;
    end
  end

  wire fall_act = fall_raw && seen_rise_reg; // RULE10 RULE7

  // ****************************************
  // Receive shifter.
  // ****************************************
  logic [6:0] rx_shift_reg;
  logic [2:0] rx_cnt_reg;
  logic [7:0] rx_data_reg;
  logic       rx_valid_reg;
  // Lane zero cannot listen while it drives, so reception stops during dual reads.
  wire        rx_act_ok = !dual_lane_zero_oe; // RULE8
  wire        rx_take = rx_act_ok && rise_act;
  wire        rx_done = rx_take && (rx_cnt_reg == RX_CNT_LAST);

  // A partial byte left by a short frame is dropped when the next frame opens.
  always_ff @(posedge clk_sys) begin
    if (sys_rst || open_frame) begin
      rx_shift_reg <= '0;
      rx_cnt_reg   <= RX_CNT_RST;
    end else if (rx_take) begin
      rx_shift_reg <= {rx_shift_reg[5:0], si_sync_reg}; // RULE6 RULE13
      rx_cnt_reg   <= rx_cnt_reg + 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rx_data_reg  <= BYTE_RST;
      rx_valid_reg <= 1'b0;
    end else begin
      rx_valid_reg <= rx_done;
      if (rx_done) begin
        rx_data_reg <= {rx_shift_reg, si_sync_reg}; // RULE13
      end
    end
  end

  // ****************************************
  // Transmit buffer.
  // ****************************************
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic [3:0] tx_cnt_reg;
  wire        tx_load = fall_act && drive_en && (tx_cnt_reg == TX_CNT_EMPTY);

  // The buffer is emptied when the frame closes, so stale bytes never reach a later frame.
  // The core may refill it at any time while the frame runs.
  byte_fifo #(
    .WIDTH (BYTE_BITS),
    .DEPTH (TX_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .flush     (close_frame),
    .in_data   (tx_data),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (tx_load)
  );

  // ****************************************
  // Transmit shifter.
  // ****************************************
  logic [7:0] tx_shift_reg;
  logic       lane_one_reg;
  logic       lane_zero_reg;
  // The step is the number of bits that leave per falling edge, two in dual reads.
  wire  [3:0] tx_step = dual_mode ? DUAL_STEP : SINGLE_STEP;
  // An empty buffer at a byte boundary sends the idle fill pattern.
  wire  [7:0] tx_word = tx_load ? (fifo_valid ? fifo_data : IDLE_FILL) : tx_shift_reg;
  wire        tx_shift = fall_act && drive_en;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || open_frame) begin
      tx_shift_reg  <= IDLE_FILL;
      tx_cnt_reg    <= TX_CNT_EMPTY;
      lane_one_reg  <= 1'b1;
      lane_zero_reg <= 1'b1;
    end else if (tx_shift) begin
      lane_one_reg <= tx_word[7]; // RULE7 RULE9 RULE13
      if (dual_mode) begin
        lane_zero_reg <= tx_word[6]; // RULE8
        tx_shift_reg  <= {tx_word[5:0], 2'b00};
      end else begin
        tx_shift_reg <= {tx_word[6:0], 1'b0};
      end
      if (tx_load) begin
        tx_cnt_reg <= 4'(BYTE_BITS) - tx_step;
      end else begin
        tx_cnt_reg <= (tx_cnt_reg > tx_step) ? tx_cnt_reg - tx_step : TX_CNT_EMPTY;
      end
    end
  end

  // ****************************************
  // Pin drivers and status.
  // ****************************************
  logic so_oe_reg;
  logic lane_zero_oe_reg;
  logic selected_reg;
  logic standby_reg;
  logic paused_reg;
  logic frame_start_reg;
  logic frame_end_reg;

  // The output enables follow the next state, so a pause or deselect floats the pins at once.
  // Standby waits for a running program or erase to finish after deselect.
  // The frame pulses last one cycle each.
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      so_oe_reg        <= 1'b0;
      lane_zero_oe_reg <= 1'b0;
      selected_reg     <= 1'b0;
      standby_reg      <= 1'b1;
      paused_reg       <= 1'b0;
      frame_start_reg  <= 1'b0;
      frame_end_reg    <= 1'b0;
    end else begin
      so_oe_reg        <= drive_now; // RULE2 RULE9 RULE11
      lane_zero_oe_reg <= drive_now && dual_mode; // RULE8
      selected_reg     <= (state_next != ST_IDLE); // RULE1
      standby_reg      <= (state_next == ST_IDLE) && !op_busy; // RULE2 RULE5
      paused_reg       <= (state_next == ST_PAUSED); // RULE11
      frame_start_reg  <= open_frame;
      frame_end_reg    <= close_frame;
    end
  end

  assign dual_lane_one_out  = lane_one_reg;
  assign dual_lane_one_oe   = so_oe_reg;
  assign dual_lane_zero_out = lane_zero_reg;
  assign dual_lane_zero_oe  = lane_zero_oe_reg;
  assign rx_data            = rx_data_reg;
  assign rx_valid           = rx_valid_reg;
  assign selected           = selected_reg;
  assign standby            = standby_reg;
  assign paused             = paused_reg;
  assign frame_start        = frame_start_reg;
  assign frame_end          = frame_end_reg;

endmodule : serial_flash_spi_front_end

`default_nettype wire

// *** bench/spi_front_properties.sv ***
// Concurrent checks on the ports of the serial flash front end.
`default_nettype none

module spi_front_properties (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sck,
  input wire logic dual_lane_zero_oe,
  input wire logic dual_lane_one_out,
  input wire logic dual_lane_one_oe,
  input wire logic op_busy,
  input wire logic dual_mode,
  input wire logic rx_valid,
  input wire logic selected,
  input wire logic standby,
  input wire logic paused
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  so_float_a: assert property (!selected && !$past(selected) |-> !dual_lane_one_oe)
    else $error("serial output driven while deselected");
  sel_standby_a: assert property (selected && $past(selected) |-> !standby)
    else $error("standby while selected");
  busy_hold_a: assert property ($past(op_busy) && !$past(sys_rst) |-> !standby)
    else $error("standby while busy");
  busy_done_a: assert property ($fell(op_busy) && !selected |-> ##[1:2] standby)
    else $error("no standby after busy");
  pause_float_a: assert property (paused && $past(paused) |-> !dual_lane_one_oe)
    else $error("output driven while paused");
  lane_pair_a: assert property (dual_lane_zero_oe |-> dual_lane_one_oe)
    else $error("lane zero driven alone");
  lane_mode_a: assert property (!dual_mode && !$past(dual_mode) |-> !dual_lane_zero_oe)
    else $error("lane zero driven outside dual read");
  rx_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
    else $error("received bytes too close");
  out_fall_a: assert property ($changed(dual_lane_one_out) && dual_lane_one_oe
      && $past(dual_lane_one_oe) |-> ($past(sck, 4) && !$past(sck, 3))
      || ($past(sck, 5) && !$past(sck, 4)) || ($past(sck, 6) && !$past(sck, 5)))
    else $error("output changed away from a falling clock");
endmodule : spi_front_properties

bind serial_flash_spi_front_end spi_front_properties u_spi_front_properties (
  .clk_sys, .sys_rst, .sck, .dual_lane_zero_oe, .dual_lane_one_out, .dual_lane_one_oe,
  .op_busy, .dual_mode, .rx_valid, .selected, .standby, .paused
);

`default_nettype wire

// *** bench/host_spi_model.sv ***
// Behavioural host master that frames and clocks the serial link.
`default_nettype none

module host_spi_model (
  input  wire logic clk_sys,
  input  wire logic lane0,
  input  wire logic lane1,
  output var logic  cs_n,
  output var logic  sck,
  output var logic  si
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // Lanes are read late in the high phase because the oversampled output lags the fall.
  task automatic frame(input logic sel, input logic mode3, input logic dual,
                       input logic [7:0] mosi, output logic [7:0] seen);
    int i;
    seen = 8'h00;
    sck  <= mode3;
    cs_n <= !sel;
    repeat (4) @(posedge clk_sys);
    for (i = 0; i < 10; i++) begin
      if (i > 1 && (!dual || i < 6)) begin
        seen = dual ? {seen[5:0], lane1, lane0} : {seen[6:0], lane1};
      end
      if (i < 9) begin
        sck <= 1'b0;
        si  <= mosi[3'(7 - i)];
        repeat (4) @(posedge clk_sys);
        sck <= 1'b1;
        repeat (4) @(posedge clk_sys);
      end
    end
    sck <= mode3;
    repeat (4) @(posedge clk_sys);
    cs_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : frame
endmodule : host_spi_model

`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the serial flash front end.
`default_nettype none

module tb_top import spi_front_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;

  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  logic            hold_n = 1'b1;
  logic            op_busy = 1'b0;
  logic            drive_en = 1'b0;
  logic            dual_mode = 1'b0;
  logic            tx_valid = 1'b0;
  logic [7:0]      tx_data = 8'h00;
  logic            float_bit = 1'b0;
  wire logic       cs_n, sck, si, oe0, out0, oe1, out1, tx_ready, rx_valid;
  wire logic       selected, standby, paused, frame_start, frame_end;
  wire logic [7:0] rx_data;
  wire logic       pin0 = oe0 ? out0 : si;
  wire logic       pin1 = oe1 ? out1 : float_bit;
  logic [7:0]      q[$];
  logic [7:0]      seen, m, b, rx_got;
  logic            ok;
  int              seed = 32'hab83;
  int              mismatches = 0;
  int              num_checks = 0;
  int              rx_cnt = 0;
  int              frames_opened = 0;
  int              frames_closed = 0;
  int              i;

  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) float_bit <= ~float_bit;
  always @(posedge clk_sys) begin
    if (frame_start === 1'b1) frames_opened <= frames_opened + 1;
    if (frame_end === 1'b1) frames_closed <= frames_closed + 1;
  end
  always @(posedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      rx_got <= rx_data;
      rx_cnt <= rx_cnt + 1;
    end
  end

  serial_flash_spi_front_end u_serial_flash_spi_front_end (
    .clk_sys, .sys_rst, .cs_n, .sck, .hold_n, .dual_lane_zero_in(pin0),
    .dual_lane_zero_out(out0), .dual_lane_zero_oe(oe0), .dual_lane_one_out(out1),
    .dual_lane_one_oe(oe1), .op_busy, .drive_en, .dual_mode, .tx_data, .tx_valid,
    .tx_ready, .rx_data, .rx_valid, .selected, .standby, .paused, .frame_start,
    .frame_end
  );
  host_spi_model u_host_spi_model (.clk_sys, .lane0(pin0), .lane1(pin1), .cs_n, .sck, .si);

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t ns: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic idle_flags(input string what);
    check({4'h0, selected, standby, oe1, oe0}, 8'h04, what);
  endtask : idle_flags

  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    idle_flags("reset flags");
    m = 8'($random(seed));
    u_host_spi_model.frame(1'b0, 1'b0, 1'b0, m, seen);
    check(8'(rx_cnt), 8'h00, "bytes while deselected");
    idle_flags("deselected flags");
    $display("test deselect done");
    drive_en <= 1'b1;
    tx_valid <= 1'b1;
    for (i = 0; i < 10; i++) begin
      b = 8'($random(seed));
      tx_data <= b;
      @(negedge clk_sys);
      ok = tx_ready;
      @(posedge clk_sys);
      if (ok === 1'b1) q.push_back(b);
    end
    tx_valid <= 1'b0;
    check(8'(q.size()), 8'(FIFO_DEPTH), "words before refusal");
    check({7'h00, tx_ready}, 8'h00, "full fifo ready");
    m = 8'($random(seed));
    u_host_spi_model.frame(1'b1, 1'b0, 1'b0, m, seen);
    check(rx_got, m, "mode 0 received");
    check(seen, q[0], "mode 0 sent");
    repeat (2) @(posedge clk_sys);
    idle_flags("closed flags");
    check({7'h00, tx_ready}, 8'h01, "flushed fifo ready");
    q.delete();
    $display("test mode 0 done");
    m = 8'($random(seed));
    u_host_spi_model.frame(1'b1, 1'b1, 1'b0, m, seen);
    check(rx_got, m, "mode 3 received");
    check(seen, IDLE_FILL, "mode 3 idle fill");
    $display("test mode 3 done");
    b = 8'($random(seed));
    tx_data <= b;
    tx_valid <= 1'b1;
    @(posedge clk_sys);
    tx_valid <= 1'b0;
    dual_mode <= 1'b1;
    u_host_spi_model.frame(1'b1, 1'b0, 1'b1, m, seen);
    check(seen, b, "dual byte");
    dual_mode <= 1'b0;
    $display("test dual done");
    op_busy <= 1'b1;
    u_host_spi_model.frame(1'b1, 1'b0, 1'b0, m, seen);
    check({7'h00, standby}, 8'h00, "standby while busy");
    op_busy <= 1'b0;
    repeat (3) @(posedge clk_sys);
    idle_flags("busy finished");
    $display("test busy done");
    fork
      u_host_spi_model.frame(1'b1, 1'b0, 1'b0, m, seen);
      begin
        repeat (5) @(posedge clk_sys);
        hold_n <= 1'b0;
        repeat (6) @(negedge clk_sys);
        check({6'h00, paused, oe1}, 8'h02, "paused output");
        @(posedge clk_sys);
        hold_n <= 1'b1;
      end
    join
    $display("test pause done");
    repeat (2) @(posedge clk_sys);
    check(8'(frames_opened), 8'h05, "frames opened");
    check(8'(frames_closed), 8'h05, "frames closed");
    $display("test frame pulses done");
    complete_run();
  end

  // The tests need about 530 clocks; this limit of 5000 clocks leaves a wide margin.
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
endmodule : tb_top

`default_nettype wire
